// ==== src/usbetf_frame_map.sv ====
// Endpoint table address logic, frame record writer and event flags
//
// Chosen here: the Avalon-MM register port.
`default_nettype none

module usbetf_frame_map
  import usbetf_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        ce,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sof_valid,
  input  wire logic [10:0] sof_number,
  input  wire logic        sof_crc_err,
  input  wire logic        sof_stuff_err,
  input  wire logic [7:0]  bus_events,
  input  wire logic [1:0]  xfer_events,
  input  wire logic        acc_req,
  input  wire logic [3:0]  acc_ep,
  input  wire logic        acc_in,
  input  wire logic [2:0]  acc_byte,
  input  wire logic        acc_we,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic [1:0]  acc_ep_type,
  input  wire logic        acc_multi,
  input  wire logic [15:0] acc_aux_cur,
  input  wire logic [9:0]  acc_pkt_bytes,
  input  wire logic [15:0] acc_done_bytes,
  output logic             acc_ack,
  output logic             acc_refused,
  output logic      [7:0]  acc_rdata,
  output logic      [15:0] acc_aux_next,
  output logic             acc_out_full,
  output logic             mem_req,
  output logic             mem_we,
  output logic      [15:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [7:0]  mem_rdata,
  output logic             bus_event_irq,
  output logic             transfer_done_irq,
  output logic      [7:0]  irq_vector
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic        wait_ff,      nxt_wait;
  logic [31:0] rdata_ff,     nxt_rdata;
  logic [7:0]  main_ctrl_ff, nxt_main_ctrl;
  logic [15:0] tbl_base_ff,  nxt_tbl_base;
  logic [7:0]  mask_a_ff,    nxt_mask_a;
  logic [7:0]  mask_b_ff,    nxt_mask_b;
  logic [7:0]  flags_a_ff,   nxt_flags_a;
  logic [7:0]  flags_b_ff,   nxt_flags_b;
  logic        bus_irq_ff,   nxt_bus_irq;
  logic        xfer_irq_ff,  nxt_xfer_irq;
  logic [7:0]  vector_ff,    nxt_vector;
  logic [10:0] sof_num_ff,   nxt_sof_num;
  logic        sof_err_ff,   nxt_sof_err;
  logic        sof_pend_ff,  nxt_sof_pend;
  usbetf_state_t state_ff,   nxt_state;
  logic        mreq_ff,      nxt_mreq;
  logic        mwe_ff,       nxt_mwe;
  logic [15:0] maddr_ff,     nxt_maddr;
  logic [7:0]  mwdata_ff,    nxt_mwdata;
  logic        ack_ff,       nxt_ack;
  logic        refused_ff,   nxt_refused;
  logic [7:0]  ardata_ff,    nxt_ardata;
  logic [15:0] aux_next_ff,  nxt_aux_next;
  logic        out_full_ff,  nxt_out_full;

  logic        enable;
  logic [3:0]  highest_endpoint_index;
  logic        bus_take;
  logic        commit;
  logic        sof_take;
  logic        refuse;
  logic [15:0] entry_addr;
  logic [15:0] frame_lo_addr;
  logic [15:0] frame_hi_addr;
  logic [15:0] aux_sum;
  logic        out_full;
  logic [7:0]  sof_lo_byte;
  logic [7:0]  sof_hi_byte;

  assign enable   = main_ctrl_ff[USBETF_ENABLE_BIT];
  assign highest_endpoint_index    = main_ctrl_ff[USBETF_HIGHEST_ENDPOINT_INDEX_W-1:0];
  // Answer one cycle after the request, commit in the waitrequest-low cycle
  assign bus_take = (avs_read || avs_write) && wait_ff;
  assign commit   = avs_write && !wait_ff && avs_byteenable[0];
  assign sof_take = sof_valid && enable;
  // Frame record bytes, reserved bits kept at zero
  assign sof_lo_byte = sof_num_ff[7:0];
  assign sof_hi_byte = {sof_err_ff, 4'h0, sof_num_ff[USBETF_SOF_NUM_W-1:8]};

  // ****************************************************************
  // Helpers
  // ****************************************************************
  usbetf_addr_gen u_addr_gen (
    .base          (tbl_base_ff),
    .ep            (acc_ep),
    .is_in         (acc_in),
    .byte_idx      (acc_byte),
    .highest_endpoint_index         (highest_endpoint_index),
    .entry_addr    (entry_addr),
    .frame_lo_addr (frame_lo_addr),
    .frame_hi_addr (frame_hi_addr)
  );

  usbetf_aux_acc #(.AUX_W(16), .CNT_W(10)) u_aux_acc (
    .aux_cur    (acc_aux_cur),
    .pkt_bytes  (acc_pkt_bytes),
    .done_bytes (acc_done_bytes),
    .aux_next   (aux_sum),
    .out_full   (out_full)
  );

  // ****************************************************************
  // Register bus slave and event flags
  // ****************************************************************
  // Flags: hardware set wins over a software clear in the same cycle
  always_comb begin
    nxt_wait      = wait_ff;
    nxt_rdata     = rdata_ff;
    nxt_main_ctrl = main_ctrl_ff;
    nxt_tbl_base  = tbl_base_ff;
    nxt_mask_a    = mask_a_ff;
    nxt_mask_b    = mask_b_ff;
    nxt_flags_a   = flags_a_ff;
    nxt_flags_b   = flags_b_ff;
    if (bus_take) begin
      nxt_wait  = 1'b0;
      nxt_rdata = USBETF_RD_ZERO;
      if (avs_read) begin
        unique case (avs_address)
          USBETF_REG_MAIN_CTRL:   nxt_rdata[7:0] = main_ctrl_ff;
          USBETF_REG_TBL_LO:      nxt_rdata[7:0] = tbl_base_ff[7:0];
          USBETF_REG_TBL_HI:      nxt_rdata[7:0] = tbl_base_ff[15:8];
          USBETF_REG_MASK_A:      nxt_rdata[7:0] = mask_a_ff;
          USBETF_REG_MASK_B:      nxt_rdata[7:0] = mask_b_ff;
          USBETF_REG_FLAGS_A_CLR,
          USBETF_REG_FLAGS_A_SET: nxt_rdata[7:0] = flags_a_ff;
          USBETF_REG_FLAGS_B_CLR,
          USBETF_REG_FLAGS_B_SET: nxt_rdata[7:0] = flags_b_ff;
          USBETF_REG_SOF_LO:      nxt_rdata[7:0] = sof_lo_byte;
          USBETF_REG_SOF_HI:      nxt_rdata[7:0] = sof_hi_byte;
          default:                nxt_rdata = USBETF_RD_ZERO;
        endcase
      end
    end else begin
      nxt_wait = 1'b1;
    end
    if (commit) begin
      unique case (avs_address)
        USBETF_REG_MAIN_CTRL:   nxt_main_ctrl      = avs_writedata[7:0];
        USBETF_REG_TBL_LO:      nxt_tbl_base[7:0]  = avs_writedata[7:0];
        USBETF_REG_TBL_HI:      nxt_tbl_base[15:8] = avs_writedata[7:0];
        USBETF_REG_MASK_A:      nxt_mask_a         = avs_writedata[7:0];
        USBETF_REG_MASK_B:      nxt_mask_b = avs_writedata[7:0] & USBETF_FLAGS_B_USED;
        USBETF_REG_FLAGS_A_CLR: nxt_flags_a = flags_a_ff & ~avs_writedata[7:0];
        USBETF_REG_FLAGS_A_SET: nxt_flags_a = flags_a_ff | avs_writedata[7:0];
        USBETF_REG_FLAGS_B_CLR: nxt_flags_b = flags_b_ff & ~avs_writedata[7:0];
        USBETF_REG_FLAGS_B_SET:
          nxt_flags_b = flags_b_ff | (avs_writedata[7:0] & USBETF_FLAGS_B_USED);
        default: ;
      endcase
    end
    nxt_flags_a = nxt_flags_a | bus_events;
    nxt_flags_a[USBETF_FLAG_SOF_BIT] = nxt_flags_a[USBETF_FLAG_SOF_BIT] | sof_take;
    nxt_flags_b = nxt_flags_b | {6'h00, xfer_events};
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wait_ff      <= 1'b1;
      rdata_ff     <= USBETF_RD_ZERO;
      main_ctrl_ff <= USBETF_RST_BYTE;
      tbl_base_ff  <= USBETF_RST_WORD;
      mask_a_ff    <= USBETF_RST_BYTE;
      mask_b_ff    <= USBETF_RST_BYTE;
      flags_a_ff   <= USBETF_RST_BYTE;
      flags_b_ff   <= USBETF_RST_BYTE;
    end else if (ce) begin
      wait_ff      <= nxt_wait;
      rdata_ff     <= nxt_rdata;
      main_ctrl_ff <= nxt_main_ctrl;
      tbl_base_ff  <= nxt_tbl_base;
      mask_a_ff    <= nxt_mask_a;
      mask_b_ff    <= nxt_mask_b;
      flags_a_ff   <= nxt_flags_a;
      flags_b_ff   <= nxt_flags_b;
    end
  end

  // ****************************************************************
  // Interrupt outputs, two vectors
  // ****************************************************************
  // Bus-event vector takes priority when both are pending
  always_comb begin
    nxt_bus_irq  = |(flags_a_ff & mask_a_ff);
    nxt_xfer_irq = |(flags_b_ff & mask_b_ff);
    if (nxt_bus_irq) begin
      nxt_vector = USBETF_VEC_BUS_EVENT;
    end else if (nxt_xfer_irq) begin
      nxt_vector = USBETF_VEC_XFER_DONE;
    end else begin
      nxt_vector = USBETF_VEC_NONE;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bus_irq_ff  <= 1'b0;
      xfer_irq_ff <= 1'b0;
      vector_ff   <= USBETF_VEC_NONE;
    end else if (ce) begin
      bus_irq_ff  <= nxt_bus_irq;
      xfer_irq_ff <= nxt_xfer_irq;
      vector_ff   <= nxt_vector;
    end
  end

  // ****************************************************************
  // Frame capture and table access sequencer
  // ****************************************************************
  // Disabled entries past the first byte, and aux bytes lacking multipacket, are refused unread
  assign refuse = !enable || (acc_ep > highest_endpoint_index)
                  || ((acc_ep_type == USBETF_EP_DISABLED)
                      && (acc_byte != USBETF_DESC_FIRST))
                  || (!acc_multi && ((acc_byte == USBETF_DESC_AUX_LO)
                                     || (acc_byte == USBETF_DESC_AUX_HI)));

  // A frame seen in the cycle the high byte is acknowledged re-arms the write afterwards
  always_comb begin
    nxt_state    = state_ff;
    nxt_mreq     = mreq_ff;
    nxt_mwe      = mwe_ff;
    nxt_maddr    = maddr_ff;
    nxt_mwdata   = mwdata_ff;
    nxt_ack      = 1'b0;
    nxt_refused  = 1'b0;
    nxt_ardata   = ardata_ff;
    nxt_aux_next = aux_next_ff;
    nxt_out_full = out_full_ff;
    nxt_sof_num  = sof_num_ff;
    nxt_sof_err  = sof_err_ff;
    nxt_sof_pend = sof_pend_ff;
    unique case (state_ff)
      USBETF_ST_IDLE: begin
        if (sof_pend_ff) begin
          nxt_state  = USBETF_ST_SOF_LO;
          nxt_mreq   = 1'b1;
          nxt_mwe    = 1'b1;
          nxt_maddr  = frame_lo_addr;
          nxt_mwdata = sof_lo_byte;
        end else if (acc_req && !ack_ff) begin
          nxt_aux_next = aux_sum;
          nxt_out_full = out_full;
          if (refuse) begin
            nxt_ack     = 1'b1;
            nxt_refused = 1'b1;
          end else begin
            nxt_state  = USBETF_ST_ACC;
            nxt_mreq   = 1'b1;
            nxt_mwe    = acc_we;
            nxt_maddr  = entry_addr;
            nxt_mwdata = acc_wdata;
          end
        end
      end
      USBETF_ST_SOF_LO: begin
        if (mem_ack) begin
          nxt_state  = USBETF_ST_SOF_HI;
          nxt_maddr  = frame_hi_addr;
          nxt_mwdata = sof_hi_byte;
        end
      end
      USBETF_ST_SOF_HI: begin
        if (mem_ack) begin
          nxt_state    = USBETF_ST_IDLE;
          nxt_mreq     = 1'b0;
          nxt_mwe      = 1'b0;
          nxt_sof_pend = 1'b0;
        end
      end
      USBETF_ST_ACC: begin
        if (mem_ack) begin
          nxt_state  = USBETF_ST_IDLE;
          nxt_mreq   = 1'b0;
          nxt_mwe    = 1'b0;
          nxt_ack    = 1'b1;
          nxt_ardata = mem_rdata;
        end
      end
    endcase
    if (sof_take) begin
      nxt_sof_num  = sof_number;
      nxt_sof_err  = sof_crc_err || sof_stuff_err;
      nxt_sof_pend = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff    <= USBETF_ST_IDLE;
      mreq_ff     <= 1'b0;
      mwe_ff      <= 1'b0;
      maddr_ff    <= USBETF_RST_WORD;
      mwdata_ff   <= USBETF_RST_BYTE;
      ack_ff      <= 1'b0;
      refused_ff  <= 1'b0;
      ardata_ff   <= USBETF_RST_BYTE;
      aux_next_ff <= USBETF_RST_WORD;
      out_full_ff <= 1'b0;
      sof_num_ff  <= '0;
      sof_err_ff  <= 1'b0;
      sof_pend_ff <= 1'b0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      mreq_ff     <= nxt_mreq;
      mwe_ff      <= nxt_mwe;
      maddr_ff    <= nxt_maddr;
      mwdata_ff   <= nxt_mwdata;
      ack_ff      <= nxt_ack;
      refused_ff  <= nxt_refused;
      ardata_ff   <= nxt_ardata;
      aux_next_ff <= nxt_aux_next;
      out_full_ff <= nxt_out_full;
      sof_num_ff  <= nxt_sof_num;
      sof_err_ff  <= nxt_sof_err;
      sof_pend_ff <= nxt_sof_pend;
    end
  end

  // Outputs straight from flops
  assign avs_readdata      = rdata_ff;
  assign avs_waitrequest   = wait_ff;
  assign acc_ack           = ack_ff;
  assign acc_refused       = refused_ff;
  assign acc_rdata         = ardata_ff;
  assign acc_aux_next      = aux_next_ff;
  assign acc_out_full      = out_full_ff;
  assign mem_req           = mreq_ff;
  assign mem_we            = mwe_ff;
  assign mem_addr          = maddr_ff;
  assign mem_wdata         = mwdata_ff;
  assign bus_event_irq     = bus_irq_ff;
  assign transfer_done_irq = xfer_irq_ff;
  assign irq_vector        = vector_ff;

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_sof_number: assert property (@(posedge clock) disable iff (!rstn)
    (ce && sof_take) |=> (sof_num_ff == $past(sof_number)))
    else $error("frame number not captured");
  chk_sof_error: assert property (@(posedge clock) disable iff (!rstn)
    (ce && sof_take) |=> (sof_hi_byte[USBETF_SOF_ERR_BIT]
                          == ($past(sof_crc_err) || $past(sof_stuff_err))))
    else $error("frame error flag wrong");
  chk_entry_addr: assert property (@(posedge clock) disable iff (!rstn)
    (ce && state_ff == USBETF_ST_IDLE && nxt_state == USBETF_ST_ACC)
    |=> (mem_addr == usbetf_entry_addr($past(tbl_base_ff), $past(acc_ep),
                                       $past(acc_in), $past(acc_byte))))
    else $error("endpoint entry address wrong");
  chk_frame_addr: assert property (@(posedge clock) disable iff (!rstn)
    (ce && state_ff == USBETF_ST_IDLE && nxt_state == USBETF_ST_SOF_LO)
    |=> (mem_addr == usbetf_frame_addr($past(tbl_base_ff), $past(highest_endpoint_index))) && mem_we)
    else $error("frame record address wrong");
  chk_aux_guard: assert property (@(posedge clock) disable iff (!rstn)
    (ce && state_ff == USBETF_ST_IDLE && !sof_pend_ff && acc_req && !ack_ff
     && !acc_multi && acc_byte == USBETF_DESC_AUX_HI)
    |=> acc_refused && acc_ack && !mem_req)
    else $error("aux byte touched without multipacket");
  chk_bus_vector: assert property (@(posedge clock) disable iff (!rstn)
    (ce && |(flags_a_ff & mask_a_ff))
    |=> bus_event_irq && (irq_vector == USBETF_VEC_BUS_EVENT))
    else $error("bus event vector not raised");
  chk_disabled_entry: assert property (@(posedge clock) disable iff (!rstn)
    (ce && state_ff == USBETF_ST_IDLE && !sof_pend_ff && acc_req && !ack_ff
     && acc_ep_type == USBETF_EP_DISABLED && acc_byte != USBETF_DESC_FIRST)
    |=> !mem_req ##1 (!mem_req || state_ff != USBETF_ST_ACC))
    else $error("disabled entry accessed");
  chk_aux_sum: assert property (@(posedge clock) disable iff (!rstn)
    (ce && state_ff == USBETF_ST_IDLE && !sof_pend_ff && acc_req && !ack_ff)
    |=> (acc_aux_next == $past(acc_aux_cur) + 16'($past(acc_pkt_bytes))))
    else $error("aux total wrong");
  chk_flag_set: assert property (@(posedge clock) disable iff (!rstn)
    (ce && xfer_events[1]) |=> flags_b_ff[1]
    ##1 (!$past(ce) || !$past(mask_b_ff[1]) || transfer_done_irq))
    else $error("transfer flag lost");
  chk_bus_answer: assert property (@(posedge clock) disable iff (!rstn)
    (ce && (avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
    else $error("bus answer late");

endmodule : usbetf_frame_map
`default_nettype wire

// ==== src/usbetf_pkg.sv ====
// Shared offsets, field positions, states and address helpers of the endpoint table block
`default_nettype none
package usbetf_pkg;

  // ****************************************************************
  // Register word indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [5:0]  USBETF_REG_MAIN_CTRL   = 6'h00;
  localparam logic [5:0]  USBETF_REG_TBL_LO      = 6'h06;
  localparam logic [5:0]  USBETF_REG_TBL_HI      = 6'h07;
  localparam logic [5:0]  USBETF_REG_MASK_A      = 6'h08;
  localparam logic [5:0]  USBETF_REG_MASK_B      = 6'h09;
  localparam logic [5:0]  USBETF_REG_FLAGS_A_CLR = 6'h0a;
  localparam logic [5:0]  USBETF_REG_FLAGS_A_SET = 6'h0b;
  localparam logic [5:0]  USBETF_REG_FLAGS_B_CLR = 6'h0c;
  localparam logic [5:0]  USBETF_REG_FLAGS_B_SET = 6'h0d;
  localparam logic [5:0]  USBETF_REG_SOF_LO      = 6'h10;
  localparam logic [5:0]  USBETF_REG_SOF_HI      = 6'h11;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam logic [7:0]  USBETF_RST_BYTE        = 8'h00;
  localparam logic [15:0] USBETF_RST_WORD        = 16'h0000;
  localparam logic [31:0] USBETF_RD_ZERO         = 32'h0000_0000;
  localparam int unsigned USBETF_HIGHEST_ENDPOINT_INDEX_W         = 4;
  localparam int unsigned USBETF_ENABLE_BIT      = 7;
  localparam int unsigned USBETF_SOF_ERR_BIT     = 7;
  localparam int unsigned USBETF_SOF_NUM_W       = 11;
  localparam int unsigned USBETF_FLAG_SOF_BIT    = 7;
  localparam logic [7:0]  USBETF_FLAGS_B_USED    = 8'h03;
  localparam logic [2:0]  USBETF_DESC_FIRST      = 3'h0;
  localparam logic [2:0]  USBETF_DESC_AUX_LO     = 3'h6;
  localparam logic [2:0]  USBETF_DESC_AUX_HI     = 3'h7;
  localparam logic [1:0]  USBETF_EP_DISABLED     = 2'h0;

  // ****************************************************************
  // Table geometry and interrupt vector offsets
  // ****************************************************************
  localparam int unsigned USBETF_EP_SHIFT        = 4;
  localparam logic [15:0] USBETF_IN_OFFSET       = 16'h0008;
  localparam int unsigned USBETF_FRAME_SHIFT     = 4;
  localparam logic [15:0] USBETF_ONE16           = 16'h0001;
  localparam logic [7:0]  USBETF_VEC_BUS_EVENT   = 8'h00;
  localparam logic [7:0]  USBETF_VEC_XFER_DONE   = 8'h02;
  localparam logic [7:0]  USBETF_VEC_NONE        = 8'hff;

  typedef enum logic [1:0] {
    USBETF_ST_IDLE   = 2'b00,
    USBETF_ST_SOF_LO = 2'b01,
    USBETF_ST_SOF_HI = 2'b10,
    USBETF_ST_ACC    = 2'b11
  } usbetf_state_t;

  // Byte address of one descriptor byte of an endpoint entry
  function automatic logic [15:0] usbetf_entry_addr(input logic [15:0] base,
                                                    input logic [3:0]  ep,
                                                    input logic        is_in,
                                                    input logic [2:0]  byte_idx);
    logic [15:0] ofs;
    ofs = 16'(ep) << USBETF_EP_SHIFT;
    return base + ofs + (is_in ? USBETF_IN_OFFSET : USBETF_RST_WORD) + 16'(byte_idx);
  endfunction : usbetf_entry_addr

  // Byte address of the frame record that follows the last endpoint
  function automatic logic [15:0] usbetf_frame_addr(input logic [15:0] base,
                                                    input logic [3:0]  highest_endpoint_index);
    return base + ((16'(highest_endpoint_index) + USBETF_ONE16) << USBETF_FRAME_SHIFT);
  endfunction : usbetf_frame_addr

endpackage : usbetf_pkg
`default_nettype wire

// ==== src/usbetf_addr_gen.sv ====
// Address generator for endpoint entries and the frame record
`default_nettype none
module usbetf_addr_gen
  import usbetf_pkg::*;
(
  input  wire logic [15:0] base,
  input  wire logic [3:0]  ep,
  input  wire logic        is_in,
  input  wire logic [2:0]  byte_idx,
  input  wire logic [3:0]  highest_endpoint_index,
  output logic      [15:0] entry_addr,
  output logic      [15:0] frame_lo_addr,
  output logic      [15:0] frame_hi_addr
);
  // Entry stride of sixteen, IN half eight bytes on
  assign entry_addr    = usbetf_entry_addr(base, ep, is_in, byte_idx);
  // Frame record sits right past the highest endpoint pair
  assign frame_lo_addr = usbetf_frame_addr(base, highest_endpoint_index);
  assign frame_hi_addr = frame_lo_addr + USBETF_ONE16;
endmodule : usbetf_addr_gen
`default_nettype wire

// ==== src/usbetf_aux_acc.sv ====
// Multipacket auxiliary value arithmetic
`default_nettype none
module usbetf_aux_acc
  import usbetf_pkg::*;
#(
  parameter int unsigned AUX_W = 16,
  parameter int unsigned CNT_W = 10
) (
  input  wire logic [AUX_W-1:0] aux_cur,
  input  wire logic [CNT_W-1:0] pkt_bytes,
  input  wire logic [AUX_W-1:0] done_bytes,
  output logic      [AUX_W-1:0] aux_next,
  output logic                  out_full
);
  // IN side: running total of bytes sent
  assign aux_next = aux_cur + AUX_W'(pkt_bytes);
  // OUT side: value is the whole transfer size, compare only
  assign out_full = (done_bytes >= aux_cur);
endmodule : usbetf_aux_acc
`default_nettype wire

// ==== test/usbetf_mem.sv ====
// Byte memory model answering the block's memory master
`default_nettype none
module usbetf_mem (
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [15:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic             mem_ack,
  output logic      [7:0]  mem_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [logic [15:0]];
  int         dly = 0;
  // Wait follows the address; idle read data toggles so a stale byte never passes
  always @(posedge clock) begin
    if (!rstn) begin
      mem_ack   <= 1'b0;
      mem_rdata <= 8'h5a;
      dly = 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack && dly++ >= int'(mem_addr[1:0])) begin
        dly = 0;
        mem_ack <= 1'b1;
        if (mem_we) mem[mem_addr] = mem_wdata;
        else mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 8'h00;
      end
    end
  end
endmodule : usbetf_mem
`default_nettype wire

// ==== test/tb.sv ====
// Random and corner-case bench for the endpoint table block
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import usbetf_pkg::*;
  logic        clock = 1'b0, rstn = 1'b0, ce = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        sof_valid = 1'b0, sof_crc_err = 1'b0, sof_stuff_err = 1'b0, acc_req = 1'b0;
  logic        acc_in = 1'b0, acc_we = 1'b1, acc_multi = 1'b0, avs_waitrequest, acc_ack;
  logic        acc_refused, acc_out_full, mem_req, mem_we, mem_ack, bus_event_irq;
  logic        transfer_done_irq;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [15:0] acc_aux_cur = 16'h0, acc_done_bytes = 16'h0, acc_aux_next, mem_addr, base, exp;
  logic [10:0] sof_number = 11'h0;
  logic [9:0]  acc_pkt_bytes = 10'h0;
  logic [7:0]  bus_events = 8'h0, acc_wdata = 8'h0, acc_rdata, mem_wdata, mem_rdata;
  logic [7:0]  irq_vector, q;
  logic [5:0]  avs_address = 6'h0;
  logic [3:0]  avs_byteenable = 4'hf, acc_ep = 4'h0;
  logic [2:0]  acc_byte = 3'h0;
  logic [1:0]  xfer_events = 2'h0, acc_ep_type = 2'h0;
  int          num_errors = 0, checked = 0, seed = 32'h5d8f;
  always #2.5 clock = ~clock;
  usbetf_frame_map u_usbetf_frame_map (.*);
  usbetf_mem u_usbetf_mem (.*);
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One register access; an edge passes after release so strobes never double up
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d);
    {avs_address, avs_write, avs_read, avs_writedata} <= {a, w, !w, 24'h0, d};
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    {avs_write, avs_read} <= 2'b00;
    @(posedge clock);
  endtask : bus
  task automatic acc(input logic [3:0] ep, input logic in, input logic [2:0] b,
                     input logic [1:0] ty, input logic mu, output logic r);
    {acc_ep, acc_in, acc_byte, acc_ep_type, acc_multi, acc_req} <= {ep, in, b, ty, mu, 1'b1};
    {acc_wdata, acc_aux_cur, acc_pkt_bytes, acc_done_bytes} <=
      {8'($random(seed)), 16'($random(seed)), 10'($random(seed)), 16'($random(seed))};
    do @(posedge clock); while (acc_ack !== 1'b1);
    r = acc_refused;
    acc_req <= 1'b0;
    @(posedge clock);
  endtask : acc
  task automatic finish_test();
    $display("TB: %0d checks, %0d errors", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  // Watchdog: run needs under a thousand cycles
  initial begin
    #50us;
    num_errors++;
    finish_test();
  end
  initial begin
    logic [3:0] e;
    logic [2:0] b;
    logic [1:0] t;
    logic       d, m, r, w, bad;
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    chk("vector_rst", 16'h00ff, 16'(irq_vector));
    for (int i = 0; i < 4; i++) begin
      bus(USBETF_REG_SOF_LO + 6'(i / 2), !i[0], 8'h07);
      chk("sof_ro", 16'h0, 16'(q));
    end
    $display("TB: test registers done");
    base = 16'($random(seed));
    bus(USBETF_REG_TBL_LO, 1'b1, base[7:0]);
    bus(USBETF_REG_TBL_HI, 1'b1, base[15:8]);
    bus(USBETF_REG_MAIN_CTRL, 1'b1, 8'h83);
    for (int i = 0; i < 60; i++) begin
      {w, e, d, b, t, m} = 12'($random(seed));
      e[3] = 1'b0;
      exp = base + {8'h0, e, 4'h0} + {12'h0, d, 3'h0} + {13'h0, b};
      q = 8'($random(seed));
      u_usbetf_mem.mem[exp] = q;
      acc_we <= w;
      acc(e, d, b, t, m, r);
      bad = e > 4'h3 || (t == USBETF_EP_DISABLED && b != 3'h0) || (b > 3'h5 && !m);
      chk("refused", 16'(bad), 16'(r));
      chk("entry", (bad || !w) ? 16'(q) : 16'(acc_wdata), 16'(u_usbetf_mem.mem[exp]));
      if (!bad && !w) chk("rdata", 16'(q), 16'(acc_rdata));
      if (!bad) chk("aux", acc_aux_cur + 16'(acc_pkt_bytes), acc_aux_next);
      chk("out_full", 16'(acc_done_bytes >= acc_aux_cur), 16'(acc_out_full));
    end
    $display("TB: test entries done");
    for (int i = 0; i < 3; i++) begin
      {sof_number, sof_crc_err, sof_stuff_err} <= {11'($random(seed)), 2'(i)};
      sof_valid <= 1'b1;
      @(posedge clock);
      sof_valid <= 1'b0;
      repeat (30) @(posedge clock);
      exp = {8'h0, i != 0, 4'h0, sof_number[10:8]};
      chk("frame_lo", 16'(sof_number[7:0]), 16'(u_usbetf_mem.mem[base + 16'h40]));
      chk("frame_hi", exp, 16'(u_usbetf_mem.mem[base + 16'h41]));
      bus(USBETF_REG_SOF_HI, 1'b0, 8'h00);
      chk("sof_hi", exp, 16'(q));
    end
    $display("TB: test frames done");
    bus(USBETF_REG_FLAGS_A_CLR, 1'b1, 8'hff);
    bus(USBETF_REG_MASK_A, 1'b1, 8'h7f);
    bus(USBETF_REG_MASK_B, 1'b1, 8'h02);
    exp = {8'h0, 8'($random(seed)) | 8'h01};
    {bus_events, xfer_events} <= {exp[7:0], 2'h2};
    @(posedge clock);
    {bus_events, xfer_events} <= 10'h0;
    bus(USBETF_REG_FLAGS_A_SET, 1'b0, 8'h00);
    chk("flags_a", exp, 16'(q));
    chk("vec_bus", 16'h0300, {6'h0, bus_event_irq, transfer_done_irq, irq_vector});
    bus(USBETF_REG_FLAGS_A_CLR, 1'b1, 8'hff);
    bus(USBETF_REG_FLAGS_B_SET, 1'b1, 8'h01);
    chk("vec_xfer", 16'h0102, {6'h0, bus_event_irq, transfer_done_irq, irq_vector});
    bus(USBETF_REG_FLAGS_B_CLR, 1'b1, 8'h02);
    bus(USBETF_REG_FLAGS_B_CLR, 1'b0, 8'h00);
    chk("flags_b", 16'h0001, 16'(q));
    chk("vec_none", 16'h00ff, {6'h0, bus_event_irq, transfer_done_irq, irq_vector});
    $display("TB: test interrupts done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
